// >>> lpf_pkg.sv
// Package: register map, field layout and timing constants for the LED PWM frame player
package lpf_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE_CFG      = 8'h00;  // Mode field carrier (bits 6:5)
  localparam logic [7:0] ADDR_CHAN_CFG      = 8'h04;  // Shared channel LED/port select
  localparam logic [7:0] ADDR_PORT_DIR      = 8'h05;  // port_direction
  localparam logic [7:0] ADDR_PORT_OUT      = 8'h06;  // port_output_level
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h07;  // port_change_irq_mask
  localparam logic [7:0] ADDR_INPUT_STATE   = 8'h08;  // port_input_state
  localparam logic [7:0] ADDR_SAMPLE_DIV    = 8'h09;  // audio_sample_divisor
  localparam logic [7:0] ADDR_DUTY_FIRST    = 8'h10;  // channel_duty_array, channel 16
  localparam logic [7:0] ADDR_DUTY_LAST     = 8'h1f;  // channel_duty_array, channel 1
  localparam logic [7:0] ADDR_FRAME_FIRST   = 8'h20;  // frame_store_array start
  localparam logic [7:0] ADDR_FRAME_LAST    = 8'haf;  // frame_store_array end
  localparam logic [7:0] ADDR_COMMIT        = 8'hb0;  // duty_commit
  localparam logic [7:0] ADDR_FRAME_DELAY   = 8'hb6;  // frame_interval
  localparam logic [7:0] ADDR_FRAME_START   = 8'hb7;  // first_frame_select
  // Field layout
  localparam int MODE_LSB    = 5;
  localparam int SEL_LSB     = 5;   // Delay and start select sit in bits 7:5
  localparam int FRAME_BYTES = 18;  // Two enable bytes then sixteen duty bytes
  localparam int FRAME_COUNT = 8;
  localparam int CHAN_COUNT  = 16;
  localparam logic [7:0] COMMIT_VALUE = 8'h00;
  localparam logic [7:0] RESET_ZERO   = 8'h00;
  localparam logic [7:0] ENABLE_ALL   = 8'hff;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_AUTO   = 2'b01,
    MODE_AUDIO  = 2'b10
  } lpf_mode_type;
  // Timing
  localparam int CLK_HZ         = 20_000_000;
  localparam int SAMPLE_BASE_HZ = 100_000;
  localparam int SAMPLE_TICK_CYCLES = CLK_HZ / SAMPLE_BASE_HZ;  // 100 kHz base tick
  localparam int DELAY_BASE_US  = 4870;  // Shortest frame delay, 4.87 ms
  localparam int DELAY_UNIT_US  = 9500;  // Doubling series from 9.5 ms
  localparam int DELAY_BASE_CYCLES = (CLK_HZ / 1000) * DELAY_BASE_US / 1000;
  localparam int DELAY_UNIT_CYCLES = (CLK_HZ / 1000) * DELAY_UNIT_US / 1000;
endpackage

// >>> lpf_player.sv
// LED PWM engine with frame store, frame player, audio frame selector and shared port
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Channel config bit picks LED or port
// - Direction bit zero output, one input
// - Output level bit drives pin low/high
// - Interrupt enable bit is active low
// - Input pins captured into state register
// - Enabled input change pulls interrupt low
// - Reading state register releases interrupt
// - Audio sampled at 100kHz over divisor
// - Sixteen eight-bit duty registers, 256 steps
// - Duty addresses descend from channel sixteen
// - Duty writes shadowed until zero commit
// - Eight frames of eighteen bytes each
// - Frame delay selected by bits 7:5
// - Start frame selected by bits 7:5
// - Frames ascend to eight then wrap
// - Mode 00 drives from duty registers
// - Mode 01 plays stored frames automatically
// - Mode 10 frame follows audio level
module lpf_player #(
  parameter int DELAY_BASE = lpf_pkg::DELAY_BASE_CYCLES,  // 4.87 ms in cycles
  parameter int DELAY_UNIT = lpf_pkg::DELAY_UNIT_CYCLES   // 9.5 ms in cycles
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wr_en,          // Register write strobe
  input  wire logic        rd_en,          // Register read strobe
  input  wire logic [7:0]  addr,           // Register address
  input  wire logic [7:0]  wdata,          // Write data
  output logic      [7:0]  rdata,          // Read data, valid cycle after rd_en
  input  wire logic [7:0]  audio_level,    // Audio converter result
  input  wire logic [7:0]  shared_in,      // Shared pin input levels, channel 9 in bit 0
  output logic [7:0]       shared_out,     // Shared pin port output level
  output logic [7:0]       shared_oe,      // Shared pin port output enable
  output logic [15:0]      led_on,         // LED sink enables, channel 1 in bit 0
  output logic [1:0]       mode_out,       // Current operating mode
  output logic             irq_out_n       // Interrupt, active low
);

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [1:0]  mode;                  // Operating mode
  logic [7:0]  chan_cfg;              // One per shared channel: port use
  logic [7:0]  port_direction;        // One: input
  logic [7:0]  port_output_level;
  logic [7:0]  port_change_irq_mask;  // Zero enables change detect
  logic [7:0]  port_input_state;
  logic [7:0]  sample_rate_divisor;
  logic [2:0]  frame_delay_select;
  logic [2:0]  frame_start_select;
  logic [7:0]  shadow_duty [16];      // Index 0 is channel 1
  logic [7:0]  active_duty [16];
  logic [7:0]  frame_store [144];     // Eight 18-byte frames, no reset
  logic [2:0]  cur_frame;             // Frame shown in frame modes

  // Channel index for a duty address: lowest address is channel sixteen
  function automatic logic [3:0] duty_chan(input logic [7:0] a);
    logic [7:0] off;
    off = a - lpf_pkg::ADDR_DUTY_FIRST;
    return 4'(4'hf - off[3:0]);
  endfunction

  // Frame store byte index for a frame, byte within frame
  function automatic logic [7:0] fs_index(input logic [2:0] f, input logic [4:0] b);
    return 8'(f * lpf_pkg::FRAME_BYTES + b);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      mode                 <= 2'h0;
      chan_cfg             <= lpf_pkg::RESET_ZERO;
      port_direction       <= lpf_pkg::RESET_ZERO;
      port_output_level    <= lpf_pkg::RESET_ZERO;
      port_change_irq_mask <= lpf_pkg::RESET_ZERO;
      sample_rate_divisor  <= lpf_pkg::RESET_ZERO;
      frame_delay_select   <= 3'h0;
      frame_start_select   <= 3'h0;
    end else if (wr_en) begin
      if (addr == lpf_pkg::ADDR_MODE_CFG) begin
        mode <= wdata[lpf_pkg::MODE_LSB +: 2];
      end else if (addr == lpf_pkg::ADDR_CHAN_CFG) begin
        chan_cfg <= wdata;
      end else if (addr == lpf_pkg::ADDR_PORT_DIR) begin
        port_direction <= wdata;
      end else if (addr == lpf_pkg::ADDR_PORT_OUT) begin
        port_output_level <= wdata;
      end else if (addr == lpf_pkg::ADDR_IRQ_MASK) begin
        port_change_irq_mask <= wdata;
      end else if (addr == lpf_pkg::ADDR_SAMPLE_DIV) begin
        sample_rate_divisor <= wdata;
      end else if (addr == lpf_pkg::ADDR_FRAME_DELAY) begin
        frame_delay_select <= wdata[lpf_pkg::SEL_LSB +: 3];
      end else if (addr == lpf_pkg::ADDR_FRAME_START) begin
        frame_start_select <= wdata[lpf_pkg::SEL_LSB +: 3];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Duty shadow and commit: writes land in shadow, zero commit copies all
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < lpf_pkg::CHAN_COUNT; i++) begin
        shadow_duty[i] <= lpf_pkg::RESET_ZERO;
        active_duty[i] <= lpf_pkg::RESET_ZERO;
      end
    end else begin
      if (wr_en && addr >= lpf_pkg::ADDR_DUTY_FIRST && addr <= lpf_pkg::ADDR_DUTY_LAST) begin
        shadow_duty[duty_chan(addr)] <= wdata;
      end
      // Non-zero commit values are ignored
      if (wr_en && addr == lpf_pkg::ADDR_COMMIT && wdata == lpf_pkg::COMMIT_VALUE) begin
        for (int i = 0; i < lpf_pkg::CHAN_COUNT; i++) begin
          active_duty[i] <= shadow_duty[i];
        end
      end
    end
  end

  // Frame store writes; contents undefined until software fills them
  always_ff @(posedge clk) begin
    if (wr_en && addr >= lpf_pkg::ADDR_FRAME_FIRST && addr <= lpf_pkg::ADDR_FRAME_LAST) begin
      frame_store[8'(addr - lpf_pkg::ADDR_FRAME_FIRST)] <= wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared port: capture inputs and detect change on enabled inputs
  logic [7:0] watch;  // Pins in port use, input, with detection enabled
  logic       changed;
  assign watch   = chan_cfg & port_direction & ~port_change_irq_mask;
  assign changed = |((shared_in ^ port_input_state) & watch);

  always_ff @(posedge clk) begin
    if (srst) begin
      port_input_state <= lpf_pkg::RESET_ZERO;
    end else begin
      // Only input pins follow; other bits hold their last value
      for (int i = 0; i < 8; i++) begin
        if (chan_cfg[i] && port_direction[i]) begin
          port_input_state[i] <= shared_in[i];
        end
      end
    end
  end

  // Interrupt: a change in the same cycle as a read keeps it asserted
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_out_n <= 1'b1;
    end else if (changed) begin
      irq_out_n <= 1'b0;
    end else if (rd_en && addr == lpf_pkg::ADDR_INPUT_STATE) begin
      irq_out_n <= 1'b1;
    end
  end

  // Pin drive: only port-use outputs are enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      shared_out <= lpf_pkg::RESET_ZERO;
      shared_oe  <= lpf_pkg::RESET_ZERO;
    end else begin
      shared_out <= port_output_level;
      shared_oe  <= chan_cfg & ~port_direction;
    end
  end

  // Register read: only the state register reads back, others read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= lpf_pkg::RESET_ZERO;
    end else if (rd_en) begin
      if (addr == lpf_pkg::ADDR_INPUT_STATE) begin
        rdata <= port_input_state;
      end else begin
        rdata <= lpf_pkg::RESET_ZERO;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Audio sampler: 100 kHz base tick divided by the divisor
  logic [$clog2(lpf_pkg::SAMPLE_TICK_CYCLES)-1:0] base_cnt;
  logic [7:0] div_cnt;
  logic       sample_now;  // One-cycle sample enable
  always_ff @(posedge clk) begin
    if (srst) begin
      base_cnt   <= '0;
      div_cnt    <= 8'h00;
      sample_now <= 1'b0;
    end else begin
      sample_now <= 1'b0;
      if (base_cnt == ($bits(base_cnt))'(lpf_pkg::SAMPLE_TICK_CYCLES - 1)) begin
        base_cnt <= '0;
        if (sample_rate_divisor == 8'h00) begin
          div_cnt <= 8'h00;  // sampling halted
        end else if (div_cnt >= sample_rate_divisor - 8'h01) begin
          div_cnt    <= 8'h00;
          sample_now <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end else begin
        base_cnt <= base_cnt + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame delay timer and frame sequencing
  logic [31:0] delay_cnt;
  logic [31:0] delay_len;
  logic [1:0]  prev_mode;
  always_comb begin
    // 4.87 ms for code 0, otherwise 9.5 ms doubled per step
    if (frame_delay_select == 3'h0) begin
      delay_len = 32'(DELAY_BASE);
    end else begin
      delay_len = 32'(DELAY_UNIT) << (frame_delay_select - 3'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_frame <= 3'h0;
      delay_cnt <= 32'h0;
      prev_mode <= 2'h0;
    end else begin
      prev_mode <= mode;
      if (mode == lpf_pkg::MODE_AUTO) begin
        if (prev_mode != lpf_pkg::MODE_AUTO) begin
          cur_frame <= frame_start_select;
          delay_cnt <= 32'h0;
        end else if (delay_cnt >= delay_len - 32'h1) begin
          delay_cnt <= 32'h0;
          cur_frame <= cur_frame + 3'h1;  // wraps from eight to one
        end else begin
          delay_cnt <= delay_cnt + 32'h1;
        end
      end else if (mode == lpf_pkg::MODE_AUDIO && sample_now) begin
        cur_frame <= audio_level[7:5];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PWM: common 256-slot period, output on while slot below duty
  logic [7:0] slot;
  always_ff @(posedge clk) begin
    if (srst) begin
      slot <= 8'h00;
    end else begin
      slot <= slot + 8'h01;
    end
  end

  // Frame byte lookup: enables at bytes 0..1, duty for channel 16 first at byte 2
  always_ff @(posedge clk) begin
    if (srst) begin
      led_on   <= 16'h0000;
      mode_out <= 2'h0;
    end else begin
      mode_out <= mode;
      for (int c = 0; c < lpf_pkg::CHAN_COUNT; c++) begin
        if (c >= 8 && chan_cfg[c % 8]) begin
          led_on[c] <= 1'b0;  // pin in port use
        end else if (mode == lpf_pkg::MODE_DIRECT) begin
          led_on[c] <= slot < active_duty[c];
        end else begin
          led_on[c] <= frame_store[fs_index(cur_frame, (c < 8) ? 5'd1 : 5'd0)][c % 8]
                       && (slot < frame_store[fs_index(cur_frame, 5'(lpf_pkg::FRAME_BYTES - 1 - c))]);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_irq_set;
    @(posedge clk) disable iff (srst) changed |=> !irq_out_n;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised on change");

  property p_irq_hold;
    @(posedge clk) disable iff (srst)
      (!irq_out_n && !(rd_en && addr == lpf_pkg::ADDR_INPUT_STATE)) |=> !irq_out_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without read");

  property p_irq_release;
    @(posedge clk) disable iff (srst)
      (rd_en && addr == lpf_pkg::ADDR_INPUT_STATE && !changed) |=> irq_out_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt not released by read");

  property p_oe;
    @(posedge clk) disable iff (srst) 1'b1 |=> shared_oe == $past(chan_cfg & ~port_direction);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");

  property p_out;
    @(posedge clk) disable iff (srst) 1'b1 |=> shared_out == $past(port_output_level);
  endproperty
  a_out: assert property (p_out) else $error("pin level wrong");

  property p_commit;
    @(posedge clk) disable iff (srst)
      (wr_en && addr == lpf_pkg::ADDR_COMMIT && wdata != lpf_pkg::COMMIT_VALUE) |=> $stable(active_duty[0]);
  endproperty
  a_commit: assert property (p_commit) else $error("duty changed without zero commit");

  property p_div_zero;
    @(posedge clk) disable iff (srst) (sample_rate_divisor == 8'h00) |=> !sample_now;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("sampling with zero divisor");

  property p_slot;
    @(posedge clk) disable iff (srst) 1'b1 |=> slot == 8'($past(slot) + 8'h01);
  endproperty
  a_slot: assert property (p_slot) else $error("period counter stalled");

  property p_auto_start;
    @(posedge clk) disable iff (srst)
      (mode == lpf_pkg::MODE_AUTO && prev_mode != lpf_pkg::MODE_AUTO) |=> cur_frame == $past(frame_start_select);
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("wrong start frame");

  c_irq:    cover property (@(posedge clk) disable iff (srst) $fell(irq_out_n));
  c_commit: cover property (@(posedge clk) disable iff (srst) wr_en && addr == lpf_pkg::ADDR_COMMIT);
  c_wrap:   cover property (@(posedge clk) disable iff (srst) cur_frame == 3'h7 ##1 cur_frame == 3'h0);
  c_sample: cover property (@(posedge clk) disable iff (srst) sample_now);

endmodule

// >>> lpf_host.sv
// Host model: byte writes and reads on the block's register port
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module lpf_host (
  input  wire logic       clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  // Idle bus at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'hff;
    wdata = 8'h00;
  end

  // One byte per strobe; the strobe is held for one clock cycle
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    addr  = ~a;  // Released lines must not keep the last value
    wdata = ~d;
  endtask

  // Read data is taken one cycle after the strobe
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_en = 1'b1;
    addr  = a;
    @(negedge clk);
    rd_en = 1'b0;
    addr  = ~a;
    d     = rdata;
  endtask
endmodule

// >>> test_led_pwm_frame_player_gpio.sv
// Self-checking bench for the LED PWM frame player and its shared port
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module test_led_pwm_frame_player_gpio;
  logic        clk = 1'b0;          // 20 MHz
  logic        srst = 1'b1;         // Held for 20 cycles
  logic        wr_en, rd_en;
  logic [7:0]  addr, wdata, rdata, rd, lv;
  logic [7:0]  audio_level = 8'h00; // Converter result
  logic [7:0]  shared_in = 8'h00;   // Far-side pin levels
  logic [7:0]  shared_out, shared_oe;
  logic [15:0] led_on;
  logic [1:0]  mode_out;
  logic        irq_out_n;
  logic [7:0]  duty [16];           // Index is channel minus one
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;             // Cycle stamp for frame gaps
  int          cnt [16];
  int          b, f, fr, t0, t1, period;

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Short delay parameters keep the frame timing test brief
  lpf_player #(.DELAY_BASE(20), .DELAY_UNIT(40)) lpf_player_inst (.clk(clk), .srst(srst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .audio_level(audio_level), .shared_in(shared_in),
    .shared_out(shared_out), .shared_oe(shared_oe), .led_on(led_on), .mode_out(mode_out), .irq_out_n(irq_out_n));
  lpf_host lpf_host_inst (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Frames light one channel each, so the lowest lit bit names the frame
  function automatic int frame_idx(input logic [15:0] v);
    int k;
    frame_idx = -1;
    for (k = 7; k >= 0; k--) if (v[k] === 1'b1) frame_idx = k;
  endfunction

  // Gap between frames for a delay code, in cycles
  function automatic int exp_delay(input int c);
    return (c == 0) ? 20 : (40 << (c - 1));
  endfunction

  // Wait for a lit frame other than prev; bounded
  task automatic wait_change(input int prev, output int fo, output int t);
    int n;
    fo = -1;
    for (n = 0; n < 3000 && (fo < 0 || fo == prev); n++) begin
      @(negedge clk);
      fo = frame_idx(led_on);
    end
    t = cyc;
  endtask

  // Cycles until channel one next rises; bounded
  task automatic to_rise(output int n);
    n = 0;
    while (led_on[0] === 1'b1 && n < 5000) begin @(negedge clk); n++; end
    while (led_on[0] !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run
  initial begin
    #(50 * 60000);
    mismatches++;
    $display("mismatch at %0t: timeout", $time);
    summarize();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hde15));
    repeat (20) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    check_eq({led_on, shared_oe, shared_out}, 32'h0, "reset outputs");
    check_eq({mode_out, irq_out_n}, 3'b001, "reset mode irq");
    lpf_host_inst.write(8'h0a, 8'h5c);  // Unmapped place
    lpf_host_inst.read(8'h0a, rd);
    check_eq(rd, 8'h00, "unmapped read");
    // Shared port: low nibble inputs, bit 1 change-masked
    lv = 8'($urandom);
    lpf_host_inst.write(8'h04, 8'hff);
    lpf_host_inst.write(8'h05, 8'h0f);
    lpf_host_inst.write(8'h06, lv);  // Pin level lags the register by one cycle
    lpf_host_inst.write(8'h07, 8'h02);
    check_eq(shared_oe, 8'hf0, "port enables");
    check_eq(shared_out & 8'hf0, lv & 8'hf0, "port levels");
    lpf_host_inst.read(8'h08, rd);
    check_eq(rd, 8'h00, "input state");
    @(negedge clk) shared_in = 8'h02;
    repeat (3) @(negedge clk);
    check_eq(irq_out_n, 1'b1, "masked pin irq");
    lpf_host_inst.read(8'h08, rd);
    check_eq(rd, 8'h02, "input state");
    @(negedge clk) shared_in = 8'h03;
    @(negedge clk);
    check_eq(irq_out_n, 1'b0, "change irq");
    repeat (3) @(negedge clk);
    check_eq(irq_out_n, 1'b0, "irq holds");
    lpf_host_inst.read(8'h08, rd);
    check_eq({rd, irq_out_n}, {8'h03, 1'b1}, "read clears irq");
    @(negedge clk) shared_in = 8'h13;  // Output pin moves
    repeat (3) @(negedge clk);
    check_eq(irq_out_n, 1'b1, "output pin irq");
    lpf_host_inst.write(8'h04, 8'h00);
    @(negedge clk) shared_in = 8'h12;
    repeat (3) @(negedge clk);
    check_eq({shared_oe, irq_out_n}, 9'h001, "led use pin");
    // Direct duties, corners first, then random
    for (b = 0; b < 16; b++) begin
      duty[b] = (b == 0) ? 8'h80 : (b == 1) ? 8'h00 : (b == 2) ? 8'hff : 8'($urandom);
      lpf_host_inst.write(8'h1f - 8'(b), duty[b]);
    end
    lpf_host_inst.write(8'hb0, 8'h5a);  // Nonzero commit is ignored
    t0 = 0;
    repeat (600) @(negedge clk) if (led_on !== 16'h0) t0++;
    check_eq(t0, 0, "shadowed duty");
    lpf_host_inst.write(8'hb0, 8'h00);
    to_rise(period);
    to_rise(period);
    for (b = 0; b < 16; b++) cnt[b] = 0;
    repeat (period) @(negedge clk) for (b = 0; b < 16; b++) cnt[b] += int'(led_on[b] === 1'b1);
    for (b = 0; b < 16; b++) check_eq(cnt[b] * 256, duty[b] * period, "duty slots");
    for (b = 0; b < 16; b++) lpf_host_inst.write(8'h10 + 8'(b), 8'h00);
    lpf_host_inst.write(8'hb0, 8'h00);
    // Frame f lights only channel f+1 at full duty
    for (f = 0; f < 8; f++) for (b = 0; b < 18; b++)
      lpf_host_inst.write(8'h20 + 8'(18 * f + b), (b == 0) ? 8'h00 : (b == 1) ? 8'(8'h01 << f) : 8'hff);
    for (f = 0; f < 8; f++) begin
      lpf_host_inst.write(8'hb6, 8'(f << 5));
      lpf_host_inst.write(8'hb7, 8'(f << 5));
      lpf_host_inst.write(8'h00, 8'h00);
      lpf_host_inst.write(8'h00, 8'h20);
      @(negedge clk) check_eq(mode_out, 2'b01, "auto mode");
      wait_change(-1, fr, t0);
      check_eq(fr, f, "start frame");
      wait_change(fr, fr, t0);
      check_eq(fr, (f + 1) % 8, "next frame");
      wait_change(fr, fr, t1);
      check_eq((t1 - t0 >= exp_delay(f) - 2) && (t1 - t0 <= exp_delay(f) + 2), 1'b1, "frame gap");
    end
    // Audio picks the frame; divisor one samples every 200 cycles
    lpf_host_inst.write(8'h09, 8'h01);
    lpf_host_inst.write(8'h00, 8'h40);
    @(negedge clk) check_eq(mode_out, 2'b10, "audio mode");
    for (b = 0; b < 5; b++) begin
      @(negedge clk) audio_level = (b == 0) ? 8'h00 : (b == 1) ? 8'hff : 8'($urandom);
      repeat (450) @(negedge clk);
      wait_change(-1, fr, t0);
      check_eq(fr, audio_level[7:5], "audio frame");
    end
    lv = audio_level;
    lpf_host_inst.write(8'h09, 8'h00);  // Sampling stops
    @(negedge clk) audio_level = ~lv;
    repeat (600) @(negedge clk);
    wait_change(-1, fr, t0);
    check_eq(fr, lv[7:5], "frame kept");
    summarize();
  end
endmodule
